/* tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 20;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        start   = 1'b0;
    logic [1:0]  cmd     = 2'h0;
    logic [16:0] addr    = 17'h0_0000;
    logic [7:0]  wdata   = 8'h00;
    logic [16:0] last    = 17'h0_0000;
    logic [16:0] a_out;
    logic [7:0]  d_out;
    logic [7:0]  m_out;
    logic [7:0]  rdata;
    logic        oe_n, cs_n, gate_n, pgm_n, sup, idv, busy, done, fail, par_ok, m_drv;
    wire  [7:0]  bus = (oe_n === 1'b0) ? d_out : m_out;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          seed = 32'ha8e809ab;
    int          needed = 1;
    int          npulses = 0;
    int          low_w = 0;
    int          need [4] = '{1, 3, 25, 30};
    logic [1:0]  exp_cmd = 2'h0;
    logic [16:0] exp_addr = 17'h0_0000;
    logic [7:0]  exp_data = 8'h00;
    logic [7:0]  vd;

    always #2 clk_sys = ~clk_sys;

    uvc_ctrl #(.PULSE_CYCLES(P)) i_dut (.CLK_SYS_IN(clk_sys), .RST_IN(rst), .START_IN(start),
        .CMD_IN(cmd), .ADDR_IN(addr), .WDATA_IN(wdata), .LAST_ADDR_IN(last),
        .DATA_LINES_IN(bus), .ADDRESS_LINES_OUT(a_out), .DATA_LINES_OUT(d_out),
        .DATA_LINES_OE_N_OUT(oe_n), .CHIP_SELECT_N_OUT(cs_n), .OUTPUT_GATE_N_OUT(gate_n),
        .PROGRAM_STROBE_N_OUT(pgm_n), .PROG_SUPPLY_OUT(sup), .ID_HIGH_VOLT_OUT(idv),
        .BUSY_OUT(busy), .DONE_OUT(done), .FAIL_OUT(fail), .PARITY_OK_OUT(par_ok),
        .RDATA_OUT(rdata));

    uvc_eprom_model i_model (.clk_in(clk_sys), .addr_in(a_out), .ce_n_in(cs_n),
        .oe_n_in(gate_n), .pgm_n_in(pgm_n), .vpp_in(sup), .id_hv_in(idv), .dq_in(bus),
        .needed_in(needed), .dq_out(m_out), .dq_drv_out(m_drv));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    function automatic int exp_pulses(input int n);
        return (n > uvc_pkg::MAX_PULSES) ? uvc_pkg::MAX_PULSES : n;
    endfunction

    function automatic logic [7:0] exp_read(input int n, input logic [7:0] d);
        return (n > uvc_pkg::MAX_PULSES) ? uvc_pkg::ERASED : d;
    endfunction

    // Second START cycle carries another command and must be ignored while busy
    task automatic run_cmd(input logic [1:0] c, input logic [16:0] a, input logic [7:0] d,
                           input logic [16:0] l);
        int n;
        @(posedge clk_sys);
        exp_cmd = c;
        exp_addr = a;
        exp_data = d;
        npulses = 0;
        start <= 1'b1;
        cmd <= c;
        addr <= a;
        wdata <= d;
        last <= l;
        @(posedge clk_sys);
        cmd <= ~c;
        @(posedge clk_sys);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 5000) check("done", 1, 0);
        repeat (3) @(negedge clk_sys);
        check("busy after done", 0, busy);
    endtask

    task automatic prog_read(input logic [16:0] a, input logic [7:0] d);
        run_cmd(uvc_pkg::CMD_PROGRAM, a, d, 17'h0_0000);
        check("pulse count", exp_pulses(needed), npulses);
        check("fail flag", needed > uvc_pkg::MAX_PULSES, fail);
        run_cmd(uvc_pkg::CMD_READ, a, 8'h00, 17'h0_0000);
        check("read data", exp_read(needed, d), rdata);
    endtask

    always @(negedge clk_sys) begin
        if (!rst) begin
            if (pgm_n === 1'b0) begin
                low_w++;
                check("pulse pins", {4'b0110, exp_data, exp_addr}, {cs_n, gate_n, sup, oe_n, d_out, a_out});
            end else if (low_w != 0) begin
                check("pulse width", P, low_w);
                npulses++;
                low_w = 0;
            end
            if (idv === 1'b1) check("id address", 0, a_out & 17'h1_FDFE);
            if (exp_cmd == uvc_pkg::CMD_VERIFY_ALL && busy === 1'b1) check("verify supply", 0, sup);
            if (oe_n === 1'b0 && m_drv) check("bus contention", 0, 1);
        end
    end

    initial begin
        #120_000;
        n_errors++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check("reset state", {8'hFF, 9'h1E0}, {rdata, cs_n, gate_n, pgm_n, oe_n, sup, idv, busy, done, fail});
        for (int b = 0; b < 2; b++) begin
            run_cmd(uvc_pkg::CMD_IDENT, 17'(b), 8'h00, 17'h0_0000);
            check("id byte", b ? i_model.DEVICE_ID : i_model.MAKER_ID, rdata);
            check("id parity", 1, par_ok);
        end
        for (int k = 0; k < 4; k++) begin
            needed = need[k];
            vd = 8'($random(seed));
            if (vd == 8'hFF) vd = 8'hFE;
            prog_read(17'h0_8000 | 17'(k), vd);
        end
        for (int i = 0; i < 6; i++) begin
            needed = 1 + ({$random(seed)} % 4);
            vd = 8'($random(seed)) & 8'hFE;
            prog_read(17'h1_0000 | (17'($random(seed)) & 17'h0_FF00) | 17'(i), vd);
        end
        needed = 1;
        run_cmd(uvc_pkg::CMD_PROGRAM, 17'h0_9000, 8'hFF, 17'h0_0000);
        check("erased skip", 0, npulses);
        vd = 8'($random(seed)) & 8'h7F;
        for (int k = 0; k < 4; k++) begin
            run_cmd(uvc_pkg::CMD_PROGRAM, 17'(k), vd, 17'h0_0000);
            check("fail flag", 0, fail);
        end
        run_cmd(uvc_pkg::CMD_VERIFY_ALL, 17'h0_0000, vd, 17'h0_0003);
        check("verify pass", 0, fail);
        run_cmd(uvc_pkg::CMD_VERIFY_ALL, 17'h0_0000, vd, 17'h0_0004);
        check("verify miss", 1, fail);
        conclude();
    end
endmodule // tb_top

/* uvc_ctrl.sv */
// What this block does
// R1 - Erased cells read one; programming only clears bits, so skip all-ones bytes.
// R2 - Drive the full byte and its address together while programming.
// R3 - Enter programming with high supply, strobe low and gate high.
// R4 - One 100 us low strobe pulse per try, after lines settle.
// R5 - On verify mismatch pulse again, give up after 25 pulses.
// R6 - Step through addresses, then re-read all at normal supply.
// R7 - Ganged parts share lines; only the selected part gets chip select.
// R8 - Verify with select and gate low, strobe high, high supply kept.
// R9 - Identify: id line at high voltage, others low, selector picks byte.
// R10 - Identity bytes carry odd parity, top data bit is parity.
// R11 - Data only appears with both select and gate low.
// R12 - Gate high with select low keeps outputs floating.
// R13 - Address access delay equals select access delay.
// R14 - Data valid one gate delay after gate falls, given earlier setup.
// R15 - Select high is standby, outputs float whatever the gate.
// R16 - Select decodes the device; gate is the common read strobe.
// R17 - Hold address and select, sample after access time, float before driving; a program retry drives data on the edge the gate rises.
module uvc_ctrl #(
    parameter int PULSE_CYCLES = uvc_pkg::PULSE_CYC
) (
    input  wire logic                        CLK_SYS_IN,
    input  wire logic                        RST_IN,
    input  wire logic                        START_IN,
    input  wire logic [1:0]                  CMD_IN,
    input  wire logic [uvc_pkg::ADDR_W-1:0]  ADDR_IN,
    input  wire logic [uvc_pkg::DATA_W-1:0]  WDATA_IN,
    input  wire logic [uvc_pkg::ADDR_W-1:0]  LAST_ADDR_IN,
    input  wire logic [uvc_pkg::DATA_W-1:0]  DATA_LINES_IN,
    output logic [uvc_pkg::ADDR_W-1:0]       ADDRESS_LINES_OUT,
    output logic [uvc_pkg::DATA_W-1:0]       DATA_LINES_OUT,
    output logic                             DATA_LINES_OE_N_OUT,
    output logic                             CHIP_SELECT_N_OUT,
    output logic                             OUTPUT_GATE_N_OUT,
    output logic                             PROGRAM_STROBE_N_OUT,
    output logic                             PROG_SUPPLY_OUT,
    output logic                             ID_HIGH_VOLT_OUT,
    output logic                             BUSY_OUT,
    output logic                             DONE_OUT,
    output logic                             FAIL_OUT,
    output logic                             PARITY_OK_OUT,
    output logic [uvc_pkg::DATA_W-1:0]       RDATA_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    uvc_pkg::uvc_state_e         state_reg;
    uvc_pkg::uvc_cmd_e           cmd_reg;
    logic [uvc_pkg::CNT_W-1:0]   cnt_reg;
    logic [uvc_pkg::PCNT_W-1:0]  pulses_reg;
    logic [uvc_pkg::ADDR_W-1:0]  last_reg;
    logic [uvc_pkg::DATA_W-1:0]  wdata_reg;

    logic                        cnt_zero;
    logic                        match;
    logic                        at_last;
    localparam logic [uvc_pkg::CNT_W-1:0] PULSE_LOAD = uvc_pkg::CNT_W'(PULSE_CYCLES - 1);
    localparam logic [uvc_pkg::CNT_W-1:0] SETTLE_LOAD = uvc_pkg::CNT_W'(uvc_pkg::SETTLE_CYC - 1);
    localparam logic [uvc_pkg::CNT_W-1:0] ACCESS_LOAD = uvc_pkg::CNT_W'(uvc_pkg::ACCESS_CYC - 1);
    localparam logic [uvc_pkg::CNT_W-1:0] FLOAT_LOAD = uvc_pkg::CNT_W'(uvc_pkg::FLOAT_CYC - 1);
    localparam logic [uvc_pkg::PCNT_W-1:0] PULSE_MAX = uvc_pkg::PCNT_W'(uvc_pkg::MAX_PULSES);

    assign cnt_zero = (cnt_reg == '0);
    assign match    = (DATA_LINES_IN == wdata_reg);
    assign at_last  = (ADDRESS_LINES_OUT == last_reg);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg  <= uvc_pkg::ST_IDLE;
            cmd_reg    <= uvc_pkg::CMD_READ;
            cnt_reg    <= '0;
            pulses_reg <= '0;
            last_reg   <= uvc_pkg::ADDR_ZERO;
            wdata_reg  <= uvc_pkg::ERASED;
        end else begin
            if (!cnt_zero) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            unique case (state_reg)
                uvc_pkg::ST_IDLE: begin
                    if (START_IN) begin
                        cmd_reg    <= uvc_pkg::uvc_cmd_e'(CMD_IN);
                        wdata_reg  <= WDATA_IN;
                        last_reg   <= LAST_ADDR_IN;
                        pulses_reg <= '0;
                        if (uvc_pkg::uvc_cmd_e'(CMD_IN) == uvc_pkg::CMD_PROGRAM) begin
                            // Nothing to clear in an all-ones byte
                            if (WDATA_IN == uvc_pkg::ERASED) begin
                                state_reg <= uvc_pkg::ST_DONE; // R1
                            end else begin
                                cnt_reg   <= SETTLE_LOAD;
                                state_reg <= uvc_pkg::ST_SETTLE;
                            end
                        end else begin
                            cnt_reg   <= ACCESS_LOAD; // R13 R17
                            state_reg <= uvc_pkg::ST_SAMPLE;
                        end
                    end
                end
                uvc_pkg::ST_SETTLE: begin
                    if (cnt_zero) begin
                        cnt_reg    <= PULSE_LOAD; // R4
                        pulses_reg <= pulses_reg + 1'b1; // R5
                        state_reg  <= uvc_pkg::ST_PULSE;
                    end
                end
                uvc_pkg::ST_PULSE: begin
                    if (cnt_zero) begin
                        cnt_reg   <= FLOAT_LOAD;
                        state_reg <= uvc_pkg::ST_VSETTLE;
                    end
                end
                uvc_pkg::ST_VSETTLE: begin
                    // Wait for our drivers to release before the part drives back
                    if (cnt_zero) begin
                        cnt_reg   <= ACCESS_LOAD;
                        state_reg <= uvc_pkg::ST_SAMPLE;
                    end
                end
                uvc_pkg::ST_SAMPLE: begin
                    if (cnt_zero) begin
                        cnt_reg <= FLOAT_LOAD; // R17
                        if (cmd_reg == uvc_pkg::CMD_PROGRAM && !match) begin
                            if (pulses_reg == PULSE_MAX) begin
                                state_reg <= uvc_pkg::ST_DONE; // R5
                            end else begin
                                cnt_reg   <= SETTLE_LOAD;
                                state_reg <= uvc_pkg::ST_SETTLE; // R5
                            end
                        end else begin
                            state_reg <= uvc_pkg::ST_FLOAT;
                        end
                    end
                end
                uvc_pkg::ST_FLOAT: begin
                    if (cnt_zero) begin
                        if (cmd_reg == uvc_pkg::CMD_VERIFY_ALL && !at_last) begin
                            cnt_reg   <= ACCESS_LOAD; // R6
                            state_reg <= uvc_pkg::ST_SAMPLE;
                        end else begin
                            state_reg <= uvc_pkg::ST_DONE;
                        end
                    end
                end
                uvc_pkg::ST_DONE: begin
                    state_reg <= uvc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address and data pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ADDRESS_LINES_OUT   <= uvc_pkg::ADDR_ZERO;
            DATA_LINES_OUT      <= uvc_pkg::ERASED;
            DATA_LINES_OE_N_OUT <= 1'b1;
        end else begin
            if (state_reg == uvc_pkg::ST_IDLE && START_IN) begin
                if (uvc_pkg::uvc_cmd_e'(CMD_IN) == uvc_pkg::CMD_IDENT) begin
                    ADDRESS_LINES_OUT <= uvc_pkg::ADDR_ZERO; // R9
                    ADDRESS_LINES_OUT[uvc_pkg::SEL_LINE] <= ADDR_IN[uvc_pkg::SEL_LINE]; // R9
                end else if (uvc_pkg::uvc_cmd_e'(CMD_IN) == uvc_pkg::CMD_VERIFY_ALL) begin
                    ADDRESS_LINES_OUT <= uvc_pkg::ADDR_ZERO; // R6
                end else begin
                    ADDRESS_LINES_OUT <= ADDR_IN; // R2
                end
            end else if (state_reg == uvc_pkg::ST_FLOAT && cnt_zero &&
                         cmd_reg == uvc_pkg::CMD_VERIFY_ALL && !at_last) begin
                ADDRESS_LINES_OUT <= ADDRESS_LINES_OUT + 1'b1; // R6
            end
            DATA_LINES_OUT <= wdata_reg; // R2
            // Drive only while the part's gate is high
            DATA_LINES_OE_N_OUT <= !(state_reg == uvc_pkg::ST_SETTLE ||
                                     state_reg == uvc_pkg::ST_PULSE); // R2 R12
        end
    end

    // ------------------------------------------------------------
    // Control pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CHIP_SELECT_N_OUT    <= 1'b1;
            OUTPUT_GATE_N_OUT    <= 1'b1;
            PROGRAM_STROBE_N_OUT <= 1'b1;
            PROG_SUPPLY_OUT      <= 1'b0;
            ID_HIGH_VOLT_OUT     <= 1'b0;
        end else begin
            // Standby between commands
            CHIP_SELECT_N_OUT <= (state_reg == uvc_pkg::ST_IDLE ||
                                  state_reg == uvc_pkg::ST_DONE); // R7 R15 R16
            OUTPUT_GATE_N_OUT <= !(state_reg == uvc_pkg::ST_SAMPLE); // R8 R11 R14
            // Low from the settle end for exactly PULSE_CYCLES edges, so data holds a cycle after
            PROGRAM_STROBE_N_OUT <= !((state_reg == uvc_pkg::ST_PULSE && !cnt_zero) ||
                                      (state_reg == uvc_pkg::ST_SETTLE && cnt_zero)); // R3 R4
            PROG_SUPPLY_OUT <= (cmd_reg == uvc_pkg::CMD_PROGRAM) &&
                               (state_reg != uvc_pkg::ST_IDLE) &&
                               (state_reg != uvc_pkg::ST_DONE); // R3 R8
            ID_HIGH_VOLT_OUT <= (cmd_reg == uvc_pkg::CMD_IDENT) &&
                                (state_reg == uvc_pkg::ST_SAMPLE ||
                                 state_reg == uvc_pkg::ST_FLOAT); // R9
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            BUSY_OUT      <= 1'b0;
            DONE_OUT      <= 1'b0;
            FAIL_OUT      <= 1'b0;
            PARITY_OK_OUT <= 1'b0;
            RDATA_OUT     <= uvc_pkg::ERASED;
        end else begin
            BUSY_OUT <= (state_reg != uvc_pkg::ST_IDLE) || START_IN;
            DONE_OUT <= (state_reg == uvc_pkg::ST_DONE);
            if (state_reg == uvc_pkg::ST_IDLE && START_IN) begin
                FAIL_OUT <= 1'b0;
            end else if (state_reg == uvc_pkg::ST_SAMPLE && cnt_zero &&
                         cmd_reg != uvc_pkg::CMD_READ && cmd_reg != uvc_pkg::CMD_IDENT &&
                         !match) begin
                FAIL_OUT <= (cmd_reg == uvc_pkg::CMD_VERIFY_ALL) ||
                            (pulses_reg == PULSE_MAX); // R5 R6
            end
            if (state_reg == uvc_pkg::ST_SAMPLE && cnt_zero) begin
                RDATA_OUT     <= DATA_LINES_IN; // R17
                PARITY_OK_OUT <= uvc_pkg::odd_parity(DATA_LINES_IN); // R10
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    pulse_width_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R4
        $fell(PROGRAM_STROBE_N_OUT) |-> !PROGRAM_STROBE_N_OUT [*8])
        else $error("program strobe pulse too short");
    strobe_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R3
        !PROGRAM_STROBE_N_OUT |-> OUTPUT_GATE_N_OUT && PROG_SUPPLY_OUT)
        else $error("strobe low without gate high and high supply");
    no_contend_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R12
        !DATA_LINES_OE_N_OUT |-> OUTPUT_GATE_N_OUT)
        else $error("bus driven while part may drive");
    data_stable_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R2
        !PROGRAM_STROBE_N_OUT |-> $stable(ADDRESS_LINES_OUT) && !DATA_LINES_OE_N_OUT)
        else $error("address or data moved during pulse");
    pulse_limit_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R5
        pulses_reg <= PULSE_MAX)
        else $error("too many pulses");
    id_address_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R9
        ID_HIGH_VOLT_OUT |-> (ADDRESS_LINES_OUT[uvc_pkg::ADDR_W-1:1] == '0))
        else $error("identify with other address lines high");
    select_idle_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R15
        (state_reg == uvc_pkg::ST_IDLE) [*2] |-> CHIP_SELECT_N_OUT)
        else $error("select held while idle");
    sample_late_a: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN) // R17
        $fell(OUTPUT_GATE_N_OUT) |-> !OUTPUT_GATE_N_OUT [*8])
        else $error("gate released before access time");

    prog_pass_c: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        cmd_reg == uvc_pkg::CMD_PROGRAM && DONE_OUT && !FAIL_OUT);
    prog_retry_c: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        pulses_reg == 5'd2);
    ident_c: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        ID_HIGH_VOLT_OUT && !OUTPUT_GATE_N_OUT);
    verify_step_c: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        cmd_reg == uvc_pkg::CMD_VERIFY_ALL && $changed(ADDRESS_LINES_OUT));

endmodule // uvc_ctrl

/* uvc_eprom_model.sv */
module uvc_eprom_model #(
    parameter int         ACC_CYC   = uvc_pkg::ACCESS_CYC - 4,
    parameter int         OE_CYC    = 16,
    parameter logic [7:0] MAKER_ID  = 8'h54, // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'hA1  // Arbitrary value
) (
    input  wire logic        clk_in,
    input  wire logic [16:0] addr_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        pgm_n_in,
    input  wire logic        vpp_in,
    input  wire logic        id_hv_in,
    input  wire logic [7:0]  dq_in,
    input  int               needed_in,
    output logic [7:0]       dq_out,
    output logic             dq_drv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    int          pcnt [int];
    int          acc_cnt = 0;
    int          oe_cnt  = 0;
    logic [16:0] addr_q  = 17'h0_0000;
    logic        pgm_q   = 1'b1;
    logic [7:0]  din_q   = 8'hFF;
    function automatic logic [7:0] rd(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : 8'hFF;
    endfunction
    assign dq_drv_out = !ce_n_in && !oe_n_in;
    initial dq_out = 8'h5A;
    // Not-yet-valid or floating data toggles so a stale byte never looks right
    always @(posedge clk_in) begin
        addr_q <= addr_in;
        pgm_q <= pgm_n_in;
        if (addr_in !== addr_q || ce_n_in) acc_cnt <= 0;
        else if (acc_cnt < ACC_CYC) acc_cnt <= acc_cnt + 1;
        if (oe_n_in) oe_cnt <= 0;
        else if (oe_cnt < OE_CYC) oe_cnt <= oe_cnt + 1;
        if (!pgm_n_in) din_q <= dq_in;
        if (pgm_n_in && !pgm_q && !ce_n_in && oe_n_in && vpp_in) begin
            pcnt[addr_in] = pcnt.exists(addr_in) ? pcnt[addr_in] + 1 : 1;
            if (pcnt[addr_in] >= needed_in) mem[addr_in] = rd(addr_in) & din_q;
        end
        if (dq_drv_out && acc_cnt >= ACC_CYC && oe_cnt >= OE_CYC && id_hv_in) begin
            if ((addr_in & 17'h1_FDFE) == 17'h0_0000) dq_out <= addr_in[0] ? DEVICE_ID : MAKER_ID;
            else dq_out <= ~dq_out;
        end else if (dq_drv_out && acc_cnt >= ACC_CYC && oe_cnt >= OE_CYC) begin
            dq_out <= rd(addr_in);
        end else begin
            dq_out <= ~dq_out;
        end
    end
endmodule // uvc_eprom_model

/* uvc_pkg.sv */
package uvc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W    = 17;
    localparam int DATA_W    = 8;
    localparam int ID_LINE   = 9;
    localparam int SEL_LINE  = 0;

    localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h0_0000;
    localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h1_FFFF;
    localparam logic [DATA_W-1:0] ERASED    = 8'hFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 250;
    localparam int PULSE_US      = 100;
    localparam int PULSE_CYC     = PULSE_US * CLK_MHZ;
    localparam int SETTLE_NS     = 20;
    localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_NS     = 150;
    localparam int ACCESS_CYC    = (ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int FLOAT_NS      = 50;
    localparam int FLOAT_CYC     = (FLOAT_NS * CLK_MHZ + 999) / 1000;
    localparam int MAX_PULSES    = 25;
    localparam int CNT_W         = 16;
    localparam int PCNT_W        = 5;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_READ,
        CMD_PROGRAM,
        CMD_IDENT,
        CMD_VERIFY_ALL
    } uvc_cmd_e;

    typedef enum {
        ST_IDLE,
        ST_SETTLE,
        ST_PULSE,
        ST_VSETTLE,
        ST_SAMPLE,
        ST_FLOAT,
        ST_DONE
    } uvc_state_e;

    // Odd parity check of an identity byte, top bit is the parity bit
    function automatic logic odd_parity(input logic [DATA_W-1:0] b);
        return ^b;
    endfunction

endpackage : uvc_pkg
